//--- hw/rom_image_record_decoder.sv
// Decodes a character stream into ROM image writes, APB controlled.
// Assumes char_in is synchronous to pclk and the ROM takes one write
// per cycle with no back-pressure.
// Operation
// - Types 0 header, 1 data, 9 end
// - Data bytes written from record address upward
// - Running address checks record continuity
// - Skipped locations take configured fill byte
// - Locations below first address are filled
// - Fill byte defaults to zero
// - Word is start, eight bits, end mark
// - Characters between end and start ignored
// - Zero character stores 0, one stores 1
// - Don't-care bits resolved and reported
// - Repeat word copies previous word n times
// - Repeat count outside range flags error
// - Byte is high then low hex nibble
// - Checksum is complement of byte sum
`timescale 1ns/100ps
`default_nettype none
module rom_image_record_decoder
  import rom_image_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire char_in_t    char_in,
  output logic             char_ready,
  output rom_wr_t          rom,
  output logic             done,
  output logic             error
);

  // Decoder state
  state_t            state;
  state_t            next_state;
  logic [12:0]       run;          // Running ROM address
  logic [12:0]       next_run;
  logic [15:0]       rec_addr;     // Address field of current record
  logic [15:0]       next_rec_addr;
  logic [7:0]        rec_left;     // Bytes left in record
  logic [7:0]        next_rec_left;
  logic [1:0]        byte_idx;     // Count, addr hi, addr lo, body
  logic [1:0]        next_byte_idx;
  logic              nib_low;      // Expecting the low nibble
  logic              next_nib_low;
  logic [3:0]        hi_nib;
  logic [3:0]        next_hi_nib;
  logic [3:0]        rec_type;
  logic [3:0]        next_rec_type;
  logic [7:0]        word;         // Bit word being shifted in
  logic [7:0]        next_word;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic [7:0]        xmask;        // Don't-care positions of word
  logic [7:0]        next_xmask;
  logic [7:0]        prev_word;    // Last stored bit word
  logic [7:0]        next_prev_word;
  logic [12:0]       rep_n;        // Repeat count
  logic [12:0]       next_rep_n;
  logic [19:0]       xlog;         // Address and mask of last X word
  logic [19:0]       next_xlog;
  logic [ERR_W-1:0]  err;          // Sticky error causes
  logic [ERR_W-1:0]  err_set;
  logic              wr_we;
  logic [7:0]        wr_data;

  // Control register bits
  logic              fmt_bits;     // 0 hex records, 1 bit words
  logic              fill_ones;
  logic              x_value;

  // Character decode
  logic              is_hex;
  logic [3:0]        nibble;
  logic              is_digit;
  logic              is_space;
  logic              sum_clear;
  logic              sum_add;
  logic              sum_match;

  // Datapath helpers
  wire logic         take      = char_in.valid && char_ready;
  wire logic [7:0]   ch        = char_in.data;
  wire logic [7:0]   full_byte = {hi_nib, nibble};
  wire logic [7:0]   fill_byte = fill_ones ? FILL_ONES : FILL_ZERO;
  wire logic [12:0]  run_inc   = 13'(run + 13'd1);
  wire logic [15:0]  new_addr  = {rec_addr[15:8], full_byte};
  wire logic [15:0]  run16     = {3'b000, run};
  wire logic         x_bit     = x_value;
  wire logic [16:0]  rep_mul   = 17'({4'h0, rep_n} * 17'd10 + 17'(nibble));

  // APB decode
  wire logic         setup     = psel && !penable;
  wire logic         wr_fire   = psel && penable && pwrite && pready;
  wire logic         hit_ctrl  = (paddr == REG_CTRL);
  wire logic         hit_stat  = (paddr == REG_STATUS);
  wire logic         hit_addr  = (paddr == REG_ADDR);
  wire logic         hit_xlog  = (paddr == REG_XLOG);
  wire logic         mapped    = hit_ctrl || hit_stat || hit_addr || hit_xlog;
  wire logic         start     = wr_fire && hit_ctrl && pwdata[CTRL_START];
  wire logic [ERR_W-1:0] err_clr =
    (wr_fire && hit_stat) ? pwdata[STAT_CAUSE +: ERR_W] : '0;
  wire logic         busy      = (state != ST_IDLE) && (state != ST_DONE);
  wire logic [31:0]  status_word = {18'h0, err, 5'h0, |err,
                                    state == ST_DONE, busy};
  wire logic [31:0]  rd_mux =
    hit_ctrl ? {28'h0, x_value, fill_ones, fmt_bits, 1'b0} :
    hit_stat ? status_word :
    hit_addr ? {19'h0, run} :
    hit_xlog ? {4'h0, xlog[19:8], 8'h0, xlog[7:0]} : 32'h0;
  wire logic         next_char_ready =
    (next_state == ST_HX_START) || (next_state == ST_HX_TYPE) ||
    (next_state == ST_HX_BYTES) || (next_state == ST_BN_WAIT) ||
    (next_state == ST_BN_BITS)  || (next_state == ST_BN_COUNT);

  char_classify u_class (
    .ch       (ch),
    .is_hex   (is_hex),
    .nibble   (nibble),
    .is_digit (is_digit),
    .is_space (is_space)
  );

  byte_sum u_sum (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clear   (sum_clear),
    .add     (sum_add),
    .byte_in (full_byte),
    .match   (sum_match)
  );

  // Next-state and datapath decisions for both formats
  always_comb begin
    next_state     = state;
    next_run       = run;
    next_rec_addr  = rec_addr;
    next_rec_left  = rec_left;
    next_byte_idx  = byte_idx;
    next_nib_low   = nib_low;
    next_hi_nib    = hi_nib;
    next_rec_type  = rec_type;
    next_word      = word;
    next_bit_cnt   = bit_cnt;
    next_xmask     = xmask;
    next_prev_word = prev_word;
    next_rep_n     = rep_n;
    next_xlog      = xlog;
    err_set        = '0;
    wr_we          = 1'b0;
    wr_data        = fill_byte;
    sum_clear      = 1'b0;
    sum_add        = 1'b0;
    unique case (state)
      ST_IDLE, ST_DONE: begin
        // Wait for software to start a load
      end
      ST_HX_START: begin
        // Only the record start character opens a record
        if (take && ch == CH_REC) begin
          next_state = ST_HX_TYPE;
        end else if (take && !is_space) begin
          err_set[ERR_CHAR] = 1'b1;
        end
      end
      ST_HX_TYPE: begin
        // Header, data or end record; anything else is refused
        if (take) begin
          if (is_hex && (nibble == REC_HEADER || nibble == REC_DATA ||
                         nibble == REC_EOF)) begin
            next_rec_type = nibble;
            next_state    = ST_HX_BYTES;
            next_byte_idx = 2'd0;
            next_nib_low  = 1'b0;
            sum_clear     = 1'b1;
          end else begin
            err_set[ERR_TYPE] = 1'b1;
            next_state        = ST_HX_START;
          end
        end
      end
      ST_HX_BYTES: begin
        if (take && !is_hex) begin
          // Resynchronise on the next record start
          err_set[ERR_CHAR] = 1'b1;
          next_state        = ST_HX_START;
        end else if (take && !nib_low) begin
          next_hi_nib  = nibble;
          next_nib_low = 1'b1;
        end else if (take) begin
          next_nib_low = 1'b0;
          unique case (byte_idx)
            2'd0: begin
              // Byte count covers address, data and checksum
              sum_add       = 1'b1;
              next_rec_left = full_byte;
              next_byte_idx = 2'd1;
              if (full_byte < MIN_COUNT) begin
                err_set[ERR_TYPE] = 1'b1;
                next_state        = ST_HX_START;
              end
            end
            2'd1: begin
              sum_add       = 1'b1;
              next_rec_addr = {full_byte, 8'h00};
              next_rec_left = 8'(rec_left - 8'd1);
              next_byte_idx = 2'd2;
            end
            2'd2: begin
              sum_add       = 1'b1;
              next_rec_addr = new_addr;
              next_rec_left = 8'(rec_left - 8'd1);
              next_byte_idx = 2'd3;
              if (rec_type == REC_DATA) begin
                // Compare record start with running address
                if (new_addr < run16) begin
                  err_set[ERR_BACK] = 1'b1;
                  next_state        = ST_HX_START;
                end else if (new_addr >= {3'b000, ROM_DEPTH}) begin
                  err_set[ERR_OVER] = 1'b1;
                  next_state        = ST_HX_START;
                end else if (new_addr > run16) begin
                  next_state = ST_HX_GAP;
                end
              end
            end
            default: begin
              if (rec_left == 8'd1) begin
                // Checksum byte closes the record
                if (!sum_match)
                  err_set[ERR_CKSUM] = 1'b1;
                next_state = (rec_type == REC_EOF) ? ST_FILL_END
                                                   : ST_HX_START;
              end else begin
                sum_add       = 1'b1;
                next_rec_left = 8'(rec_left - 8'd1);
                if (rec_type == REC_DATA) begin
                  if (run == ROM_DEPTH) begin
                    err_set[ERR_OVER] = 1'b1;
                  end else begin
                    wr_we    = 1'b1;
                    wr_data  = full_byte;
                    next_run = run_inc;
                  end
                end
              end
            end
          endcase
        end
      end
      ST_HX_GAP: begin
        // Character input stalls while the gap is filled
        wr_we    = 1'b1;
        next_run = run_inc;
        if (run_inc == rec_addr[12:0])
          next_state = ST_HX_BYTES;
      end
      ST_FILL_END: begin
        // Rest of the ROM takes the fill byte after the end record
        if (run == ROM_DEPTH) begin
          next_state = ST_DONE;
        end else begin
          wr_we    = 1'b1;
          next_run = run_inc;
        end
      end
      ST_BN_WAIT: begin
        // Everything up to the start mark is dropped
        if (take && ch == CH_BEGIN) begin
          next_state   = ST_BN_BITS;
          next_bit_cnt = 4'd0;
          next_xmask   = 8'h00;
        end
      end
      ST_BN_BITS: begin
        if (take && bit_cnt == 4'd0 && ch == CH_REP) begin
          next_state = ST_BN_COUNT;
          next_rep_n = 13'd0;
        end else if (take && bit_cnt == 4'd8) begin
          if (ch == CH_END) begin
            // Word complete: store it and remember it
            wr_we          = 1'b1;
            wr_data        = word;
            next_prev_word = word;
            next_run       = run_inc;
            next_state     = (run_inc == ROM_DEPTH) ? ST_DONE
                                                    : ST_BN_WAIT;
            if (xmask != 8'h00)
              next_xlog = {run[11:0], xmask};
          end else begin
            err_set[ERR_CHAR] = 1'b1;
            next_state        = ST_BN_WAIT;
          end
        end else if (take) begin
          // Bits arrive most significant first
          next_bit_cnt = 4'(bit_cnt + 4'd1);
          if (ch == CH_ZERO) begin
            next_word = {word[6:0], 1'b0};
          end else if (ch == CH_ONE) begin
            next_word = {word[6:0], 1'b1};
          end else if (ch == CH_DONT) begin
            next_word = {word[6:0], x_bit};
            next_xmask = xmask | (8'h80 >> bit_cnt);
          end else begin
            err_set[ERR_CHAR] = 1'b1;
            next_state        = ST_BN_WAIT;
          end
        end
      end
      ST_BN_COUNT: begin
        if (take && is_digit) begin
          // Saturate so a huge count still reads as out of range
          next_rep_n = (rep_mul >= {4'h0, ROM_DEPTH}) ? ROM_DEPTH
                                                     : rep_mul[12:0];
        end else if (take && ch == CH_END) begin
          if (rep_n == 13'd0 || rep_n >= ROM_DEPTH) begin
            err_set[ERR_RANGE] = 1'b1;
            next_state         = ST_BN_WAIT;
          end else begin
            next_state = ST_BN_REPEAT;
          end
        end else if (take) begin
          err_set[ERR_CHAR] = 1'b1;
          next_state        = ST_BN_WAIT;
        end
      end
      ST_BN_REPEAT: begin
        // One copy of the previous word per cycle
        wr_we      = 1'b1;
        wr_data    = prev_word;
        next_run   = run_inc;
        next_rep_n = 13'(rep_n - 13'd1);
        if (run_inc == ROM_DEPTH) begin
          next_state = ST_DONE;
          if (rep_n != 13'd1)
            err_set[ERR_OVER] = 1'b1;
        end else if (rep_n == 13'd1) begin
          next_state = ST_BN_WAIT;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // A start restarts the load from address zero in either format
    if (start) begin
      next_run      = 13'd0;
      next_nib_low  = 1'b0;
      next_state    = pwdata[CTRL_FORMAT] ? ST_BN_WAIT : ST_HX_START;
      wr_we         = 1'b0;
    end
  end

  // Decoder registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      run       <= 13'd0;
      rec_addr  <= 16'h0000;
      rec_left  <= 8'h00;
      byte_idx  <= 2'd0;
      nib_low   <= 1'b0;
      hi_nib    <= 4'h0;
      rec_type  <= REC_HEADER;
      word      <= 8'h00;
      bit_cnt   <= 4'd0;
      xmask     <= 8'h00;
      prev_word <= FILL_ZERO;
      rep_n     <= 13'd0;
      xlog      <= 20'h00000;
    end else if (ce) begin
      state     <= next_state;
      run       <= next_run;
      rec_addr  <= next_rec_addr;
      rec_left  <= next_rec_left;
      byte_idx  <= next_byte_idx;
      nib_low   <= next_nib_low;
      hi_nib    <= next_hi_nib;
      rec_type  <= next_rec_type;
      word      <= next_word;
      bit_cnt   <= next_bit_cnt;
      xmask     <= next_xmask;
      prev_word <= next_prev_word;
      rep_n     <= next_rep_n;
      xlog      <= next_xlog;
    end
  end

  // Error causes: a new error beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err <= '0;
    else if (ce)
      err <= (err & ~err_clr) | err_set;
  end

  // Control register; fill defaults to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {x_value, fill_ones, fmt_bits} <= CTRL_RESET;
    end else if (ce && wr_fire && hit_ctrl) begin
      fmt_bits  <= pwdata[CTRL_FORMAT];
      fill_ones <= pwdata[CTRL_FILL];
      x_value   <= pwdata[CTRL_XVAL];
    end
  end

  // Registered outputs toward ROM, source and status pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom        <= '0;
      char_ready <= 1'b0;
      done       <= 1'b0;
      error      <= 1'b0;
    end else if (ce) begin
      rom        <= '{we: wr_we, addr: run[ROM_AW-1:0], data: wr_data};
      char_ready <= next_char_ready;
      done       <= (next_state == ST_DONE);
      error      <= |((err & ~err_clr) | err_set);
    end
  end

  // APB answer: data latched in setup, ready for one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= setup ? rd_mux : 32'h0;
    end
  end

endmodule // rom_image_record_decoder
`default_nettype wire

//--- hw/rom_image_pkg.sv
// Shared constants and types for the ROM image record decoder.
// Assumes a single pclk domain and 32-bit APB register access.
package rom_image_pkg;

  // ROM image geometry
  localparam int          ROM_AW    = 12;
  localparam logic [12:0] ROM_DEPTH = 13'h1000;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_XLOG   = 8'h0c;

  // Control field positions
  localparam int CTRL_START  = 0;
  localparam int CTRL_FORMAT = 1;
  localparam int CTRL_FILL   = 2;
  localparam int CTRL_XVAL   = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status and XLOG field positions
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_ERR     = 2;
  localparam int STAT_CAUSE   = 8;
  localparam int XLOG_ADDR    = 16;

  // Sticky error causes
  localparam int ERR_CKSUM = 0;
  localparam int ERR_BACK  = 1;
  localparam int ERR_CHAR  = 2;
  localparam int ERR_TYPE  = 3;
  localparam int ERR_RANGE = 4;
  localparam int ERR_OVER  = 5;
  localparam int ERR_W     = 6;

  // Character codes
  localparam logic [7:0] CH_REC   = 8'h53;
  localparam logic [7:0] CH_BEGIN = 8'h42;
  localparam logic [7:0] CH_ZERO  = 8'h4e;
  localparam logic [7:0] CH_ONE   = 8'h50;
  localparam logic [7:0] CH_DONT  = 8'h58;
  localparam logic [7:0] CH_END   = 8'h46;
  localparam logic [7:0] CH_REP   = 8'h2a;

  // Record type digits
  localparam logic [3:0] REC_HEADER = 4'h0;
  localparam logic [3:0] REC_DATA   = 4'h1;
  localparam logic [3:0] REC_EOF    = 4'h9;

  // Fill byte values
  localparam logic [7:0] FILL_ZERO = 8'h00;
  localparam logic [7:0] FILL_ONES = 8'hff;

  // Smallest legal byte count: two address bytes and a checksum
  localparam logic [7:0] MIN_COUNT = 8'h03;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } char_in_t;

  typedef struct packed {
    logic              we;
    logic [ROM_AW-1:0] addr;
    logic [7:0]        data;
  } rom_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_HX_START, ST_HX_TYPE, ST_HX_BYTES, ST_HX_GAP,
    ST_FILL_END, ST_BN_WAIT, ST_BN_BITS, ST_BN_COUNT, ST_BN_REPEAT,
    ST_DONE
  } state_t;

  // Hex digit decode: bit 4 valid, bits 3:0 value
  function automatic logic [4:0] hex_value(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39)
      return {1'b1, 4'(c - 8'h30)};
    else if (c >= 8'h41 && c <= 8'h46)
      return {1'b1, 4'(c - 8'h37)};
    else if (c >= 8'h61 && c <= 8'h66)
      return {1'b1, 4'(c - 8'h57)};
    else
      return 5'h00;
  endfunction

endpackage

//--- hw/char_classify.sv
// Character class decoder for the record decoder.
// Purely combinational; the caller qualifies with its own strobe.
`timescale 1ns/100ps
`default_nettype none
module char_classify
  import rom_image_pkg::*;
(
  input  wire logic [7:0] ch,
  output logic            is_hex,
  output logic [3:0]      nibble,
  output logic            is_digit,
  output logic            is_space
);
  logic [4:0] hv;   // Valid flag and value

  assign hv       = hex_value(ch);
  assign is_hex   = hv[4];
  assign nibble   = hv[3:0];
  // Decimal digits only, for repeat counts
  assign is_digit = (ch >= 8'h30) && (ch <= 8'h39);
  // Line breaks and blanks between records are harmless
  assign is_space = (ch == 8'h20) || (ch == 8'h0d) || (ch == 8'h0a);
endmodule // char_classify
`default_nettype wire

//--- hw/byte_sum.sv
// Eight-bit running sum of record bytes with complement compare.
// Clocked on pclk, frozen by ce like the rest of the decoder.
`timescale 1ns/100ps
`default_nettype none
module byte_sum (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic       clear,
  input  wire logic       add,
  input  wire logic [7:0] byte_in,
  output logic            match
);
  logic [7:0] sum;   // Sum of count, address and data bytes

  // Clear has priority: a record starts from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sum <= 8'h00;
    else if (ce && clear)
      sum <= 8'h00;
    else if (ce && add)
      sum <= 8'(sum + byte_in);
  end

  // Checksum byte must equal the ones' complement of the sum
  assign match = (~sum == byte_in);
endmodule // byte_sum
`default_nettype wire

//--- tb/rom_image_model.sv
// ROM image memory on the decoder's write side.
// Assumes one write pulse per location and no back-pressure.
`timescale 1ns/100ps
`default_nettype none
module rom_image_model
  import rom_image_pkg::*;
(
  input wire logic    pclk,
  input wire rom_wr_t rom
);
  logic [7:0]  mem [0:4095];  // Image bytes, X until written
  int unsigned writes = 0;    // Total write pulses seen
  // Capture every pulse; counts let the bench spot extra writes
  always @(posedge pclk) begin
    if (rom.we === 1'b1) begin
      mem[rom.addr] <= rom.data;
      writes        <= writes + 1;
    end
  end
endmodule // rom_image_model
`default_nettype wire

//--- tb/rom_image_record_decoder_monitor.sv
// Port checker for the record decoder, bound into the design.
// Assumes ce stays high whenever a load is in progress.
`timescale 1ns/100ps
`default_nettype none
module rom_image_record_decoder_monitor
  import rom_image_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        char_ready,
  input wire rom_wr_t     rom,
  input wire logic        done,
  input wire logic        error
);
  logic st_wr;  // Status write in flight, the only way to clear
  assign st_wr = psel && pwrite && paddr == REG_STATUS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; psel && !penable && ce |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_once; pready && ce |=> !pready; endproperty
  a_once: assert property (p_once) else $error("pready held");
  property p_refuse;
    pready |-> pslverr == (paddr > REG_XLOG || paddr[1:0] != 2'h0);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad slave error");
  property p_quiet; !pready |-> prdata == 32'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("read data leaks");
  property p_step;
    rom.we && $past(rom.we) |-> rom.addr == $past(rom.addr) + 12'h001;
  endproperty
  a_step: assert property (p_step) else $error("write skipped");
  property p_hold; done && $past(done) |-> !char_ready && !rom.we; endproperty
  a_hold: assert property (p_hold) else $error("busy in done");
  property p_sticky; $fell(error) |-> $past(st_wr) || $past(st_wr, 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("error lost");
  property p_last; rom.we && rom.addr == 12'hfff |=> !rom.we; endproperty
  a_last: assert property (p_last) else $error("write past end");
  cover property (rom.we && $past(rom.we));
  cover property ($rose(done));
  cover property (pready && pslverr);
endmodule // rom_image_record_decoder_monitor
bind rom_image_record_decoder rom_image_record_decoder_monitor
  rom_image_record_decoder_monitor_inst (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom(rom),
  .char_ready(char_ready), .done(done), .error(error));
`default_nettype wire

//--- tb/test_rom_image_record_decoder.sv
// Bench: register access, hex load, bit-word load, error causes.
// Assumes the ROM model and checker files are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module test_rom_image_record_decoder import rom_image_pkg::*;;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, char_ready, done, error, se;
  char_in_t    char_in = '0;
  rom_wr_t     rom;
  int          errors = 0, tests_run = 0;
  always #4 pclk = ~pclk;
  rom_image_record_decoder rom_image_record_decoder_inst (.pclk(pclk),
    .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .char_in(char_in),
    .char_ready(char_ready), .rom(rom), .done(done), .error(error));
  rom_image_model rom_image_model_inst (.pclk(pclk), .rom(rom));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task mc(input logic [11:0] a, input logic [7:0] e);
    check({24'h0, rom_image_model_inst.mem[a]}, {24'h0, e});
  endtask
  // One APB transfer; a leading edge keeps drives one per time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Each character held until taken at a ready edge
  task send(input string s);
    @(posedge pclk);
    for (int i = 0; i < s.len(); i++) begin
      char_in <= char_in_t'({1'b1, s[i]});
      @(posedge pclk);
      while (char_ready !== 1'b1) @(posedge pclk);
    end
    char_in <= '0;
  endtask
  task wait_done;
    for (int k = 0; k < 6000 && done !== 1'b1; k++) @(posedge pclk);
    // Last write lands in the model at most one edge after done rises
    @(posedge pclk);
    check({31'h0, done}, 32'h1);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_reg;
    apb(1'b0, REG_CTRL, 32'h0, rd, se);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rd, se);
    check({31'h0, se}, 32'h1);
    $display("register test ended");
  endtask
  task t_hex;
    int n;
    n = rom_image_model_inst.writes;
    apb(1'b1, REG_CTRL, 32'h5, rd, se);
    send("S0030000FCS1050002ABCD80S1040005EE08S9030000FC");
    wait_done;
    check(rom_image_model_inst.writes - n, 32'd4096);
    mc(12'h000, 8'hff);
    mc(12'h002, 8'hab);
    mc(12'h003, 8'hcd);
    mc(12'h004, 8'hff);
    mc(12'h005, 8'hee);
    mc(12'hfff, 8'hff);
    check({31'h0, error}, 32'h0);
    $display("hex load test ended");
  endtask
  task t_bits;
    int n;
    n = rom_image_model_inst.writes;
    apb(1'b1, REG_CTRL, 32'hb, rd, se);
    send("BNNNNPPPPFzzBPXNNNNNPFB*4094F");
    wait_done;
    check(rom_image_model_inst.writes - n, 32'd4096);
    mc(12'h000, 8'h0f);
    mc(12'h001, 8'hc1);
    mc(12'hfff, 8'hc1);
    apb(1'b0, REG_XLOG, 32'h0, rd, se);
    check(rd, 32'h0001_0040);
    check({31'h0, error}, 32'h0);
    $display("bit word test ended");
  endtask
  task t_err;
    apb(1'b1, REG_CTRL, 32'h3, rd, se);
    send("B*0F");
    apb(1'b0, REG_STATUS, 32'h0, rd, se);
    check(rd & 32'h1004, 32'h1004);
    apb(1'b1, REG_CTRL, 32'h1, rd, se);
    send("S0030000FCS1030000FF");
    apb(1'b0, REG_STATUS, 32'h0, rd, se);
    check(rd & 32'h0104, 32'h0104);
    // Gapless record from zero, then one after a gap with fill zero
    send("S104000011EAS104000322D6");
    apb(1'b0, REG_ADDR, 32'h0, rd, se);
    check(rd, 32'h4);
    mc(12'h000, 8'h11);
    mc(12'h002, 8'h00);
    mc(12'h003, 8'h22);
    apb(1'b1, REG_STATUS, 32'h3f00, rd, se);
    apb(1'b0, REG_STATUS, 32'h0, rd, se);
    check(rd & 32'h3f04, 32'h0);
    $display("error test ended");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reg;
    t_hex;
    t_bits;
    t_err;
    close_out;
  end
  // Loads need about 9000 cycles; this allows near three times that
  initial begin
    #200000;
    errors = errors + 1;
    close_out;
  end
endmodule // test_rom_image_record_decoder
`default_nettype wire
